// ---- logic/link_status_word_encoder.sv ----
// Purpose: builds bits 7..0 of the link status word and serves them over APB
// Assumes: link inputs synchronous to pclk; query_req is a one-cycle pulse
// Notes: the reported word is taken from one registered copy, so it is coherent
//
// Notes on behaviour
// R1: bit 0 is one while the link is up and zero while it is down.
// R2: with energy-efficient Ethernet on, low power idle still counts as link up.
// R3: bits 4..1 read zero if negotiation is unfinished, serdes is set or no mode is shared.
// R4: 1,2 are 10BASE-T half/full, 3 is 100BASE-TX half, 4 is 100BASE-T4, 6,7 are 1G half/full.
// R5: code 8 reports 10GBASE-T or any other 10 Gb/s link.
// R6: codes 9 to E report 20, 25, 40, 50, 100 and 2.5 Gb/s only when the newer protocol is on.
// R7: code F points at an enhanced speed field and needs the newer protocol.
// R8: with serdes clear the code may show a forced link setting rather than a negotiated one.
// R9: a rate with no code of its own may be shown as the nearest listed code.
// R10: the management side must not infer the media type from the code.
// R11: bit 5 is one when negotiation is enabled and the controller supports it.
// R12: bit 5 reads zero when negotiation is unsupported or disabled.
// R13: bit 6 is one once negotiation has finished, parallel detection included.
// R14: bit 6 reads zero when negotiation is unsupported or disabled.
// R15: bit 6 is present whenever bit 5 is present.
// R16: bit 7 is one when the link came from parallel detection and zero otherwise.
// R17: all bits of one answer are sampled at the same instant.
`timescale 1ns/1ps
module link_status_word_encoder (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // live link state
  input wire link_status_pkg::link_in_t link_in,
  // query port
  input wire logic query_req,
  output logic [31:0] status_word,
  output logic status_valid
);
  import link_status_pkg::*;

  // ------------------------------------------------------------
  // speed and duplex code
  // ------------------------------------------------------------
  // maps a rate to its code; codes the protocol does not allow fall back
  function automatic logic [3:0] rate_code(input link_in_t li, input logic v11,
                                           input logic nearest, input logic enh);
    logic [3:0] code;
    code = CODE_NONE;
    case (li.rate)
      RATE_10M: code = li.full_duplex ? CODE_10_FD : CODE_10_HD; // see R4
      RATE_100M: begin
        if (li.t4) begin
          code = CODE_100_T4; // see R4
        end else begin
          code = li.full_duplex ? CODE_100TX_FD : CODE_100TX_HD; // see R4
        end
      end
      RATE_1G: code = li.full_duplex ? CODE_1G_FD : CODE_1G_HD; // see R4
      RATE_10G: code = CODE_10G; // see R5
      RATE_2G5: begin
        if (v11) begin
          code = CODE_2G5; // see R6
        end else if (nearest) begin
          code = CODE_1G_FD; // see R9
        end
      end
      RATE_5G: begin
        // no code of its own: enhanced field when allowed, else nearest when enabled, else zero
        if (v11 && enh) begin
          code = CODE_ENHANCED; // see R7
        end else if (v11 && nearest) begin
          code = CODE_2G5; // see R9
        end else if (nearest) begin
          code = CODE_1G_FD; // see R9
        end
      end
      RATE_20G: code = v11 ? CODE_20G : (nearest ? CODE_10G : CODE_NONE); // see R6
      RATE_25G: code = v11 ? CODE_25G : (nearest ? CODE_10G : CODE_NONE); // see R6
      RATE_40G: code = v11 ? CODE_40G : (nearest ? CODE_10G : CODE_NONE); // see R6
      RATE_50G: code = v11 ? CODE_50G : (nearest ? CODE_10G : CODE_NONE); // see R6
      RATE_100G: code = v11 ? CODE_100G : (nearest ? CODE_10G : CODE_NONE); // see R6
      default: code = CODE_NONE;
    endcase
    return code;
  endfunction : rate_code

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  logic [CTRL_WIDTH-1:0] ctrl;
  logic v11_en;
  logic nearest_en;
  logic enh_en;
  logic an_sup;
  assign v11_en = ctrl[CTRL_V11_BIT];
  assign nearest_en = ctrl[CTRL_NEAREST_BIT];
  assign enh_en = ctrl[CTRL_ENH_BIT];
  assign an_sup = ctrl[CTRL_AN_SUP_BIT];

  // ------------------------------------------------------------
  // live word
  // ------------------------------------------------------------
  logic [31:0] next_live;
  logic [31:0] live_word;
  logic an_on;
  logic [3:0] code;

  // whole word from one set of inputs, so every field shares one instant
  always_comb begin
    an_on = an_sup & link_in.an_enabled; // see R11 see R12
    code = CODE_NONE;
    if (link_in.serdes) begin
      code = CODE_NONE; // see R3
    end else if (!an_on) begin
      code = rate_code(link_in, v11_en, nearest_en, enh_en); // see R8
    end else if (link_in.an_complete && link_in.best_found) begin
      code = rate_code(link_in, v11_en, nearest_en, enh_en);
    end else begin
      code = CODE_NONE; // see R3
    end
    next_live = WORD_RESET;
    // lpi is an idle state of a live link, not a drop
    next_live[POS_LINK] = link_in.link_up | (link_in.eee_en & link_in.lpi); // see R1 see R2
    next_live[POS_CODE_LO +: 4] = code;
    next_live[POS_AN_EN] = an_on; // see R11 see R12
    next_live[POS_AN_DONE] = an_on & link_in.an_complete; // see R13 see R14 see R15
    next_live[POS_PAR_DET] = an_on & link_in.an_complete & link_in.par_det; // see R16
  end

  // registered copy of the live word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live_word <= WORD_RESET;
    end else begin
      live_word <= next_live; // see R17
    end
  end

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  logic setup_ph;
  logic access_wr;
  logic mapped;
  logic snap_wr;
  logic [31:0] next_rdata;
  assign setup_ph = psel & ~penable;
  assign access_wr = psel & penable & pready & pwrite;
  assign mapped = (paddr == OFF_CTRL) || (paddr == OFF_LIVE) || (paddr == OFF_SNAP);
  assign snap_wr = access_wr && (paddr == OFF_SNAP);

  // read mux; unmapped reads return zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (paddr)
      OFF_CTRL: next_rdata[CTRL_WIDTH-1:0] = ctrl;
      OFF_LIVE: next_rdata = live_word;
      OFF_SNAP: next_rdata = status_word;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // answer in the first access cycle: pready is raised by the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph & ~mapped;
      prdata <= (setup_ph & ~pwrite) ? next_rdata : 32'h0000_0000;
    end
  end

  // control register write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
    end else if (access_wr && (paddr == OFF_CTRL)) begin
      ctrl <= pwdata[CTRL_WIDTH-1:0];
    end
  end

  // ------------------------------------------------------------
  // snapshot for the query response
  // ------------------------------------------------------------
  // one capture of the registered word keeps all fields coherent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_word <= WORD_RESET;
      status_valid <= 1'b0;
    end else begin
      status_valid <= query_req;
      if (query_req || snap_wr) begin
        status_word <= live_word; // see R17
      end
    end
  end

  // ------------------------------------------------------------
  // assertion helpers
  // ------------------------------------------------------------
  // forced path: serdes clear and negotiation off, so rate_code alone sets the code
  logic forced_path;
  logic enh_cause;
  logic [3:0] live_code;
  assign forced_path = !link_in.serdes && !an_on;
  // only a 5 Gb/s link may ever show the enhanced code
  assign enh_cause = v11_en & enh_en & (link_in.rate == RATE_5G);
  assign live_code = live_word[POS_CODE_LO +: 4];

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_LINK_FLAG: assert property ( // see R1
    (link_in.link_up && !link_in.lpi) |=> live_word[POS_LINK])
    else $error("link up not reported");
  AST_LPI_UP: assert property ( // see R2
    (link_in.eee_en && link_in.lpi) |=> live_word[POS_LINK])
    else $error("lpi reported as link down");
  AST_SERDES_ZERO: assert property ( // see R3
    link_in.serdes |=> live_word[4:1] == CODE_NONE)
    else $error("serdes set but code nonzero");
  AST_AN_PENDING: assert property ( // see R3
    (an_on && !link_in.an_complete) |=> live_word[4:1] == CODE_NONE)
    else $error("code nonzero before negotiation done");
  AST_10G_CODE: assert property ( // see R5
    (!link_in.serdes && !an_on && link_in.rate == RATE_10G) |=> live_word[4:1] == CODE_10G)
    else $error("10g not coded as 8");
  AST_V10_RESERVED: assert property ( // see R6
    !v11_en |=> !(live_word[4:1] inside {[CODE_20G:CODE_ENHANCED]}))
    else $error("reserved code used without newer protocol");
  AST_AN_EN_ZERO: assert property ( // see R12
    (!an_sup || !link_in.an_enabled) |=> !live_word[POS_AN_EN])
    else $error("negotiation flag set while off");
  AST_DONE_NEEDS_EN: assert property ( // see R14
    live_word[POS_AN_DONE] |-> live_word[POS_AN_EN])
    else $error("complete set without enable");
  AST_PAR_DET: assert property ( // see R16
    live_word[POS_PAR_DET] |-> $past(link_in.par_det) && live_word[POS_AN_DONE])
    else $error("parallel detect bit without cause");
  AST_SNAP_COHERENT: assert property ( // see R17
    query_req |=> status_valid && status_word == $past(live_word))
    else $error("snapshot not taken from live word");
  AST_APB_ONE_WAIT: assert property (
    (psel && !penable) |=> pready ##1 !pready)
    else $error("apb answer timing broken");
  AST_UNMAPPED_ERR: assert property (
    (psel && !penable && !mapped) |=> pready && pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  AST_CTRL_WRITE: assert property (
    (access_wr && paddr == OFF_CTRL) |=> ctrl == 4'($past(pwdata)))
    else $error("control write lost");

  // link flag
  AST_LINK_DOWN: assert property ( // see R1
    (!link_in.link_up && !(link_in.eee_en && link_in.lpi)) |=> !live_word[POS_LINK])
    else $error("link down reported as up");

  // forced codes, one per listed mode
  AST_10M_HALF: assert property ( // see R4
    (forced_path && link_in.rate == RATE_10M && !link_in.full_duplex)
    |=> live_code == CODE_10_HD)
    else $error("10m half code wrong");
  AST_10M_FULL: assert property ( // see R4
    (forced_path && link_in.rate == RATE_10M && link_in.full_duplex)
    |=> live_code == CODE_10_FD)
    else $error("10m full code wrong");
  AST_100TX_HALF: assert property ( // see R4
    (forced_path && link_in.rate == RATE_100M && !link_in.t4 && !link_in.full_duplex)
    |=> live_code == CODE_100TX_HD)
    else $error("100tx half code wrong");
  AST_100TX_FULL: assert property ( // see R4
    (forced_path && link_in.rate == RATE_100M && !link_in.t4 && link_in.full_duplex)
    |=> live_code == CODE_100TX_FD)
    else $error("100tx full code wrong");
  AST_T4_CODE: assert property ( // see R4
    (forced_path && link_in.rate == RATE_100M && link_in.t4)
    |=> live_code == CODE_100_T4)
    else $error("t4 code wrong");
  AST_1G_HALF: assert property ( // see R4
    (forced_path && link_in.rate == RATE_1G && !link_in.full_duplex)
    |=> live_code == CODE_1G_HD)
    else $error("1g half code wrong");
  AST_1G_FULL: assert property ( // see R4
    (forced_path && link_in.rate == RATE_1G && link_in.full_duplex)
    |=> live_code == CODE_1G_FD)
    else $error("1g full code wrong");

  // newer protocol codes and the enhanced pointer
  AST_V11_20G: assert property ( // see R6
    (forced_path && v11_en && link_in.rate == RATE_20G)
    |=> live_code == CODE_20G)
    else $error("20g code wrong");
  AST_V11_100G: assert property ( // see R6
    (forced_path && v11_en && link_in.rate == RATE_100G)
    |=> live_code == CODE_100G)
    else $error("100g code wrong");
  AST_ENH_CODE: assert property ( // see R7
    (live_code == CODE_ENHANCED) |-> $past(enh_cause))
    else $error("enhanced code without cause");

  // nearest fallback is a choice of the control register
  AST_NEAREST_ON: assert property ( // see R9
    (forced_path && nearest_en && !v11_en && link_in.rate == RATE_2G5)
    |=> live_code == CODE_1G_FD)
    else $error("nearest code not used");
  AST_NEAREST_OFF: assert property ( // see R9
    (forced_path && !nearest_en && !v11_en && link_in.rate == RATE_2G5)
    |=> live_code == CODE_NONE)
    else $error("uncoded rate not zero");
  AST_NO_BEST: assert property ( // see R3
    (an_on && !link_in.best_found) |=> live_code == CODE_NONE)
    else $error("code nonzero with no shared mode");

  // negotiation flags
  AST_AN_EN_SET: assert property ( // see R11
    (an_sup && link_in.an_enabled) |=> live_word[POS_AN_EN])
    else $error("negotiation flag missing");
  AST_AN_DONE_SET: assert property ( // see R13
    (an_on && link_in.an_complete) |=> live_word[POS_AN_DONE])
    else $error("complete flag missing");
  AST_DONE_ZERO: assert property ( // see R14
    !an_on |=> !live_word[POS_AN_DONE])
    else $error("complete set while negotiation off");
  AST_PAR_DET_CLEAR: assert property ( // see R16
    !link_in.par_det |=> !live_word[POS_PAR_DET])
    else $error("parallel detect bit not cleared");

  // snapshot side
  AST_SNAP_WRITE: assert property ( // see R17
    snap_wr |=> status_word == $past(live_word))
    else $error("snapshot write not taken");
  AST_VALID_CAUSE: assert property (
    status_valid |-> $past(query_req))
    else $error("valid pulse without query");

  COV_LINK_UP_1G: cover property (live_word[POS_LINK] && live_word[4:1] == CODE_1G_FD);
  COV_PAR_DET: cover property (live_word[POS_PAR_DET]);
  COV_QUERY: cover property (query_req ##1 status_valid);
  COV_BAD_ADDR: cover property (pready && pslverr);
  COV_ENHANCED: cover property (live_code == CODE_ENHANCED);
endmodule : link_status_word_encoder

// ---- logic/link_status_pkg.sv ----
// Purpose: shared constants and types for the link status word encoder
// Assumes: one 20 MHz clock, APB register access with 32-bit data
// Notes: the word layout covers bits 7..0 only; the upper bits read as zero
package link_status_pkg;
  // --------------------------------------------------------------
  // register map (byte addresses)
  // --------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_LIVE = 8'h04;
  localparam logic [7:0] OFF_SNAP = 8'h08;
  // control bit positions and reset value
  localparam int CTRL_V11_BIT = 0;
  localparam int CTRL_NEAREST_BIT = 1;
  localparam int CTRL_ENH_BIT = 2;
  localparam int CTRL_AN_SUP_BIT = 3;
  localparam int CTRL_WIDTH = 4;
  localparam logic [3:0] CTRL_RESET = 4'hb;
  // --------------------------------------------------------------
  // status word field positions
  // --------------------------------------------------------------
  localparam int POS_LINK = 0;
  localparam int POS_CODE_LO = 1;
  localparam int POS_AN_EN = 5;
  localparam int POS_AN_DONE = 6;
  localparam int POS_PAR_DET = 7;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  // speed and duplex codes
  localparam logic [3:0] CODE_NONE = 4'h0;
  localparam logic [3:0] CODE_10_HD = 4'h1;
  localparam logic [3:0] CODE_10_FD = 4'h2;
  localparam logic [3:0] CODE_100TX_HD = 4'h3;
  localparam logic [3:0] CODE_100_T4 = 4'h4;
  localparam logic [3:0] CODE_100TX_FD = 4'h5;
  localparam logic [3:0] CODE_1G_HD = 4'h6;
  localparam logic [3:0] CODE_1G_FD = 4'h7;
  localparam logic [3:0] CODE_10G = 4'h8;
  localparam logic [3:0] CODE_20G = 4'h9;
  localparam logic [3:0] CODE_25G = 4'ha;
  localparam logic [3:0] CODE_40G = 4'hb;
  localparam logic [3:0] CODE_50G = 4'hc;
  localparam logic [3:0] CODE_100G = 4'hd;
  localparam logic [3:0] CODE_2G5 = 4'he;
  localparam logic [3:0] CODE_ENHANCED = 4'hf;
  // link rate as resolved by the port logic
  typedef enum logic [3:0] {
    RATE_10M, RATE_100M, RATE_1G, RATE_2G5, RATE_5G, RATE_10G,
    RATE_20G, RATE_25G, RATE_40G, RATE_50G, RATE_100G
  } rate_t;
  // live link state from the port logic
  typedef struct packed {
    logic link_up;
    logic eee_en;
    logic lpi;
    logic serdes;
    logic an_enabled;
    logic an_complete;
    logic par_det;
    logic best_found;
    rate_t rate;
    logic full_duplex;
    logic t4;
  } link_in_t;
endpackage : link_status_pkg

// ---- dv/link_mgmt_model.sv ----
// Purpose: management side model that asks the encoder for status words
// Assumes: query_req is taken on any rising edge; status_valid one cycle later
// Notes: waits at most eight cycles so a dead answer cannot hang the run
`timescale 1ns/1ps
module link_mgmt_model (
  // clock
  input wire logic pclk,
  // query port
  output logic query_req,
  input wire logic status_valid,
  input wire logic [31:0] status_word
);
  initial query_req = 1'b0;
  // --------------------------------------------------------------
  // one query: pulse, then take the word with the valid pulse
  // --------------------------------------------------------------
  task automatic ask(output logic [31:0] w);
    int n;
    n = 0;
    @(posedge pclk);
    query_req <= 1'b1;
    @(posedge pclk);
    query_req <= 1'b0;
    do begin
      @(posedge pclk);
      n++;
    end while (status_valid !== 1'b1 && n < 8);
    // a missing answer must never look like a valid word
    // the word is passed on whole; nothing here guesses a media type from the code
    w = (status_valid === 1'b1) ? status_word : 'x;
  endtask : ask
endmodule : link_mgmt_model

// ---- dv/link_status_word_encoder_tb.sv ----
// Purpose: random self-checking bench for the link status word encoder
// Assumes: APB answer in the first access cycle; live word lags inputs by one cycle
// Notes: expectations come from a behavioural encoder written in this file
`timescale 1ns/1ps
module link_status_word_encoder_tb;
  import link_status_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, status_word, q, w;
  logic pready, pslverr, query_req, status_valid, e;
  link_in_t link_in = '0;
  link_in_t l;
  logic [3:0] cm = 4'hb;
  int bad_count = 0, n_tests = 0, cyc = 0, seed = 32'h0826;
  always #25 pclk = ~pclk;
  link_status_word_encoder uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_in(link_in), .query_req(query_req),
    .status_word(status_word), .status_valid(status_valid));
  link_mgmt_model mgmt (.pclk(pclk), .query_req(query_req), .status_valid(status_valid),
    .status_word(status_word));
  // --------------------------------------------------------------
  // reference encoder, written from the field definitions
  // --------------------------------------------------------------
  function automatic logic [31:0] enc(link_in_t x, logic [3:0] c);
    logic an;
    logic [3:0] k;
    an = x.an_enabled & c[3];
    case (x.rate)
      RATE_10M: k = x.full_duplex ? 4'h2 : 4'h1;
      RATE_100M: k = x.t4 ? 4'h4 : (x.full_duplex ? 4'h5 : 4'h3);
      RATE_1G: k = x.full_duplex ? 4'h7 : 4'h6;
      RATE_10G: k = 4'h8;
      RATE_2G5: k = c[0] ? 4'he : (c[1] ? 4'h7 : 4'h0);
      RATE_5G: k = (c[0] & c[2]) ? 4'hf : !c[1] ? 4'h0 : c[0] ? 4'he : 4'h7;
      default: k = c[0] ? 4'h3 + 4'(x.rate) : (c[1] ? 4'h8 : 4'h0);
    endcase
    if (x.serdes || (an && !(x.an_complete && x.best_found))) k = 4'h0;
    return {24'h0, an & x.an_complete & x.par_det, an & x.an_complete, an, k,
            x.link_up | (x.eee_en & x.lpi)};
  endfunction : enc
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // apb master: setup, then access until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle limit here: only the bench timeout may end a wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop
  // hang guard, far above the few thousand cycles the sequence needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(q, 32'h0000000b);
    for (int i = 0; i < 160; i++) begin
      if (i % 4 == 0) begin
        cm = 4'($random(seed));
        apb(1'b1, OFF_CTRL, {28'h0, cm});
        apb(1'b0, OFF_CTRL, 32'h0);
        chk(q, {28'h0, cm});
      end
      if (i == 80) begin
        // a second reset in mid-run must bring back the reset values
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        cm = CTRL_RESET;
        apb(1'b0, OFF_CTRL, 32'h0);
        chk(q, {28'h0, cm});
        apb(1'b0, OFF_SNAP, 32'h0);
        chk(q, WORD_RESET);
      end
      l = link_in_t'($random(seed));
      l.rate = rate_t'($unsigned($random(seed)) % 11);
      link_in <= l;
      repeat (2) @(posedge pclk);
      mgmt.ask(w);
      chk(w, enc(l, cm));
      apb(1'b0, OFF_LIVE, 32'h0);
      chk(q, enc(l, cm));
      apb(1'b0, OFF_SNAP, 32'h0);
      chk(q, w);
      if (i % 16 == 0) begin
        apb(1'b0, 8'h0c, 32'h0);
        chk({q[30:0], e}, 32'h1);
        apb(1'b1, OFF_LIVE, 32'hffffffff);
        apb(1'b0, OFF_LIVE, 32'h0);
        chk(q, enc(l, cm));
        apb(1'b1, OFF_SNAP, 32'h0);
        apb(1'b0, OFF_SNAP, 32'h0);
        chk(q, enc(l, cm));
      end
    end
    report_and_stop();
  end
endmodule : link_status_word_encoder_tb
